// file: logic/acsq_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Sample and conversion sequencer with a classic Wishbone register slave.
module acsq_sequencer
    import acsq_pkg::*;
#(
    parameter int DIV_W   = 8,
    parameter int STIME_W = 5
) (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // Wishbone slave.
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Trigger sources and power mode.
    input  wire logic              timerOneEvt,
    input  wire logic              sleepMode,
    // Conversion core.
    output acsq_core_req_type      coreReq,
    input  wire acsq_core_rsp_type coreRsp,
    // Interrupt.
    output logic                   irq
);
`include "acsq_map.svh"

    // ======================================================================
    // Register state.
    logic                      on_q;
    logic                      auto_sample_start_q;
    logic                      sample_enable_q;
    logic                      done_q;
    logic [3:0]                trig_q;
    logic [DIV_W-1:0]          div_q;
    logic [STIME_W-1:0]        stime_q;
    logic [11:0]               result_q;
    logic [`ACSQ_EVT_COUNT-1:0] status_q;
    logic [`ACSQ_EVT_COUNT-1:0] mask_q;
    logic                      ack_q;
    logic [31:0]               dat_q;

    // Sequencer state.
    acsq_state_type            state_q;
    acsq_state_type            state_d;
    logic [STIME_W-1:0]        sampCnt_q;
    logic                      convStart_q;

    // ======================================================================
    // Bus decode.
    wire logic        busReq    = wb_cyc_i && wb_stb_i;
    wire logic        busWrite  = busReq && wb_we_i && ack_q;
    wire logic        hitCtrl   = wb_adr_i == `ACSQ_OFS_CTRL;
    wire logic        hitClkCfg = wb_adr_i == `ACSQ_OFS_CLKCFG;
    wire logic        hitResult = wb_adr_i == `ACSQ_OFS_RESULT;
    wire logic        hitStatus = wb_adr_i == `ACSQ_OFS_STATUS;
    wire logic        hitMask   = wb_adr_i == `ACSQ_OFS_MASK;
    wire logic        wrCtrlLo  = busWrite && hitCtrl && wb_sel_i[0];
    wire logic        wrCtrlHi  = busWrite && hitCtrl && wb_sel_i[1];
    wire logic        wrDivLo   = busWrite && hitClkCfg && wb_sel_i[0];
    wire logic        wrDivHi   = busWrite && hitClkCfg && wb_sel_i[1];
    wire logic        wrStatus  = busWrite && hitStatus && wb_sel_i[0];
    wire logic        wrMask    = busWrite && hitMask && wb_sel_i[0];

    // Fields of the write data.
    wire logic        wSamp = wb_dat_i[`ACSQ_BIT_SAMPLE_ENABLE];
    wire logic        wAsam = wb_dat_i[`ACSQ_BIT_AUTO_SAMPLE_START];
    wire logic [3:0]  wTrig = wb_dat_i[`ACSQ_TRIG_MSB:`ACSQ_TRIG_LSB];
    wire logic        wOn   = wb_dat_i[`ACSQ_BIT_ON];

    // Module enable as it stands after this edge, so one write may enable and sample.
    wire logic        onNext = wrCtrlHi ? wOn : on_q;

    // Software sets or clears the sample enable bit.
    wire logic        swSampSet = wrCtrlLo && wSamp && !sample_enable_q;
    wire logic        swSampClr = wrCtrlLo && !wSamp && sample_enable_q;

    // ======================================================================
    // Read data assembly.
    logic [15:0] ctrlWord;
    logic [15:0] clkWord;
    logic [31:0] readMux;

    always_comb begin
        ctrlWord = 16'h0000;
        ctrlWord[`ACSQ_BIT_DONE] = done_q;
        ctrlWord[`ACSQ_BIT_SAMPLE_ENABLE] = sample_enable_q;
        ctrlWord[`ACSQ_BIT_AUTO_SAMPLE_START] = auto_sample_start_q;
        ctrlWord[`ACSQ_TRIG_MSB:`ACSQ_TRIG_LSB] = trig_q;
        ctrlWord[`ACSQ_BIT_ON] = on_q;
        clkWord = 16'h0000;
        clkWord[`ACSQ_DIV_MSB:`ACSQ_DIV_LSB] = div_q;
        clkWord[`ACSQ_STIME_MSB:`ACSQ_STIME_LSB] = stime_q;
    end

    // Unmapped offsets read as zero.
    assign readMux = hitCtrl   ? {16'h0000, ctrlWord} :
                     hitClkCfg ? {16'h0000, clkWord} :
                     hitResult ? {20'h00000, result_q} :
                     hitStatus ? {30'h00000000, status_q} :
                     hitMask   ? {30'h00000000, mask_q} :
                     32'h00000000;

    // ======================================================================
    // Wishbone answer: ack one cycle after the request, data registered.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= busReq && !ack_q;
            if (busReq && !ack_q) begin
                dat_q <= readMux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ======================================================================
    // Conversion clock enables.
    logic tadTick;

    acsq_tad_divider #(
        .DIV_W   (DIV_W)
    ) u_divider (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .run     (on_q),
        .divider (div_q),
        .cycTick (),
        .tadTick (tadTick)
    );

    // ======================================================================
    // Trigger decode.
    wire logic trigManual = trig_q == `ACSQ_TRIG_MANUAL;
    wire logic trigTmrRun = trig_q == `ACSQ_TRIG_TMR_RUN;
    wire logic trigTmrAny = trig_q == `ACSQ_TRIG_TMR_ANY;
    wire logic trigAuto   = trig_q == `ACSQ_TRIG_AUTO;

    // Sampling must have lasted at least one conversion clock period.
    wire logic [STIME_W-1:0] stimeMin = (stime_q == '0) ? STIME_W'(1) : stime_q;
    wire logic sampMet  = sampCnt_q >= stimeMin;
    wire logic tmrFire  = timerOneEvt && sampMet &&
                          (trigTmrAny || (trigTmrRun && !sleepMode));
    wire logic autoFire = trigAuto && sampMet;
    wire logic manFire  = trigManual && swSampClr && sampMet;
    wire logic convGo   = (state_q == ACSQ_SAMPLE) && (tmrFire || autoFire || manFire);
    wire logic convEnd  = (state_q == ACSQ_CONVERT) && coreRsp.convDone;

    // New sampling phase from software or from auto start.
    wire logic manSample  = (state_q == ACSQ_IDLE) && swSampSet;
    wire logic autoSample = auto_sample_start_q && ((state_q == ACSQ_IDLE) || convEnd);
    wire logic sampBegin  = onNext && (manSample || autoSample);

    // ======================================================================
    // Next state.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACSQ_IDLE: begin
                if (sampBegin) begin
                    state_d = ACSQ_SAMPLE;
                end
            end
            ACSQ_SAMPLE: begin
                if (convGo) begin
                    state_d = ACSQ_CONVERT;
                end
            end
            ACSQ_CONVERT: begin
                if (convEnd) begin
                    state_d = sampBegin ? ACSQ_SAMPLE : ACSQ_IDLE;
                end
            end
            default: begin
                state_d = ACSQ_IDLE;
            end
        endcase
        if (!onNext) begin
            state_d = ACSQ_IDLE;
        end
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= ACSQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ======================================================================
    // Sample time counter in conversion clock periods.
    always_ff @(posedge sys_clk) begin
        if (!nrst || state_q != ACSQ_SAMPLE) begin
            sampCnt_q <= '0;
        end else if (tadTick && !sampMet) begin
            sampCnt_q <= sampCnt_q + 1'b1;
        end
    end

    // ======================================================================
    // Sample enable bit, written by software and by the sequencer.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sample_enable_q <= 1'b0;
        end else if (!onNext || convGo) begin
            sample_enable_q <= 1'b0;
        end else if (sampBegin) begin
            sample_enable_q <= 1'b1;
        end
    end

    // Conversion status bit.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else if (convEnd) begin
            done_q <= 1'b1;
        end else if (manSample || convGo) begin
            done_q <= 1'b0;
        end
    end

    // Result capture at the end of a conversion.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            result_q <= 12'h000;
        end else if (convEnd) begin
            result_q <= coreRsp.result;
        end
    end

    // Conversion start strobe to the core.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            convStart_q <= 1'b0;
        end else begin
            convStart_q <= convGo;
        end
    end

    assign coreReq.sampleOn  = sample_enable_q;
    assign coreReq.convStart = convStart_q;
    assign coreReq.convClkEn = tadTick && (state_q == ACSQ_CONVERT);

    // ======================================================================
    // Software control fields; reset word held as a constant so it can be sliced.
    localparam logic [15:0] RST_CTRL = `ACSQ_RST_CTRL;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            auto_sample_start_q <= RST_CTRL[`ACSQ_BIT_AUTO_SAMPLE_START];
            trig_q <= RST_CTRL[`ACSQ_TRIG_MSB:`ACSQ_TRIG_LSB];
        end else if (wrCtrlLo) begin
            auto_sample_start_q <= wAsam;
            trig_q <= wTrig;
        end
    end

    // Module enable.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            on_q <= RST_CTRL[`ACSQ_BIT_ON];
        end else if (wrCtrlHi) begin
            on_q <= wOn;
        end
    end

    // Conversion clock divider and sample time.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            div_q   <= DIV_W'(`ACSQ_RST_DIV);
            stime_q <= STIME_W'(`ACSQ_RST_STIME);
        end else begin
            if (wrDivLo) begin
                div_q <= wb_dat_i[`ACSQ_DIV_MSB:`ACSQ_DIV_LSB];
            end
            if (wrDivHi) begin
                stime_q <= wb_dat_i[`ACSQ_STIME_MSB:`ACSQ_STIME_LSB];
            end
        end
    end

    // ======================================================================
    // Interrupt events and mask.
    logic [`ACSQ_EVT_COUNT-1:0] evt;

    assign evt[`ACSQ_EVT_DONE] = convEnd;
    assign evt[`ACSQ_EVT_SAMPLE_ENABLE] = sampBegin && !sample_enable_q;

    // Sticky status bits; a new event wins over a write-one clear.
    for (genvar i = 0; i < `ACSQ_EVT_COUNT; i++) begin : g_status
        always_ff @(posedge sys_clk) begin
            if (!nrst) begin
                status_q[i] <= 1'b0;
            end else if (evt[i]) begin
                status_q[i] <= 1'b1;
            end else if (wrStatus && wb_dat_i[i]) begin
                status_q[i] <= 1'b0;
            end
        end
    end

    // Mask register.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mask_q <= `ACSQ_RST_MASK;
        end else if (wrMask) begin
            mask_q <= wb_dat_i[`ACSQ_EVT_COUNT-1:0];
        end
    end

    assign irq = |(status_q & mask_q);

endmodule

`default_nettype wire

// file: shared/acsq_map.svh
// Function
// - With auto sample start set, a new sampling phase begins right after each conversion and the sample enable bit sets itself.
// - With auto sample start clear, sampling begins only when software writes the sample enable bit to one.
// - The sample enable bit reads one while the sample-and-hold is acquiring and zero while it holds.
// - The conversion status bit reads one after a conversion completes and zero during a conversion and while sampling started by software.
// - One timer one trigger code starts conversions even in Sleep, while code 0101 starts them only in Run or Idle.
// - The conversion clock period is the instruction cycle period times the divider value plus one.
// - The instruction cycle period is two oscillator periods, the oscillator being the system clock.
// - At least one conversion clock period of sampling is left between successive conversions.
`ifndef ACSQ_MAP_SVH
`define ACSQ_MAP_SVH

// ==========================================================================
// Register byte offsets.
`define ACSQ_OFS_CTRL      8'h00
`define ACSQ_OFS_CLKCFG    8'h04
`define ACSQ_OFS_RESULT    8'h08
`define ACSQ_OFS_STATUS    8'h0C
`define ACSQ_OFS_MASK      8'h10

// ==========================================================================
// Field positions of converter_control_one.
`define ACSQ_BIT_DONE      0
`define ACSQ_BIT_SAMPLE_ENABLE      1
`define ACSQ_BIT_AUTO_SAMPLE_START      2
`define ACSQ_TRIG_LSB      4
`define ACSQ_TRIG_MSB      7
`define ACSQ_BIT_ON        15

// Field positions of the clock configuration register.
`define ACSQ_DIV_LSB       0
`define ACSQ_DIV_MSB       7
`define ACSQ_STIME_LSB     8
`define ACSQ_STIME_MSB     12

// Event bits of the status and mask registers.
`define ACSQ_EVT_DONE      0
`define ACSQ_EVT_SAMPLE_ENABLE      1
`define ACSQ_EVT_COUNT     2

// ==========================================================================
// Reset values.
`define ACSQ_RST_CTRL      16'h0000
`define ACSQ_RST_DIV       8'h00
`define ACSQ_RST_STIME     5'h01
`define ACSQ_RST_MASK      2'h0

// ==========================================================================
// Trigger select codes.
`define ACSQ_TRIG_MANUAL   4'h0
`define ACSQ_TRIG_TMR_RUN  4'h5
`define ACSQ_TRIG_TMR_ANY  4'h6
`define ACSQ_TRIG_AUTO     4'h7

// ==========================================================================
// Timing: oscillator periods per instruction cycle.
`define ACSQ_TCY_OSC       2

`endif

// file: shared/acsq_pkg.sv
package acsq_pkg;

    // Sequencer states, Gray coded along idle, sample, convert.
    typedef enum logic [1:0] {
        ACSQ_IDLE    = 2'b00,
        ACSQ_SAMPLE  = 2'b01,
        ACSQ_CONVERT = 2'b11
    } acsq_state_type;

    // Requests to the analog sample-and-hold and conversion core.
    typedef struct packed {
        logic sampleOn;
        logic convStart;
        logic convClkEn;
    } acsq_core_req_type;

    // Answer of the conversion core.
    typedef struct packed {
        logic        convDone;
        logic [11:0] result;
    } acsq_core_rsp_type;

endpackage

// file: logic/acsq_tad_divider.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Instruction cycle and conversion clock enables.
module acsq_tad_divider
    import acsq_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Control.
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divider,
    // Enables.
    output logic                  cycTick,
    output logic                  tadTick
);
`include "acsq_map.svh"

    localparam logic [1:0] TCY_LAST = 2'(`ACSQ_TCY_OSC - 1);

    logic [1:0]       oscCnt_q;
    logic [DIV_W-1:0] tadCnt_q;

    assign cycTick = run && (oscCnt_q == TCY_LAST);
    assign tadTick = cycTick && (tadCnt_q == divider);

    // Oscillator periods counted into one instruction cycle.
    always_ff @(posedge sys_clk) begin
        if (!nrst || !run || cycTick) begin
            oscCnt_q <= 2'h0;
        end else begin
            oscCnt_q <= oscCnt_q + 2'h1;
        end
    end

    // Instruction cycles counted into one conversion clock period.
    always_ff @(posedge sys_clk) begin
        if (!nrst || !run || tadTick) begin
            tadCnt_q <= '0;
        end else if (cycTick) begin
            tadCnt_q <= tadCnt_q + 1'b1;
        end
    end

endmodule

`default_nettype wire

// file: verification/acsq_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Port checker for the sample and conversion sequencer.
module acsq_monitor
    import acsq_pkg::*;
#(
    parameter int DIV_W   = 8,
    parameter int STIME_W = 5
) (
    // Clock and reset.
    input wire logic              sys_clk,
    input wire logic              nrst,
    // Wishbone slave.
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    // Triggers, core link and interrupt.
    input wire logic              timerOneEvt,
    input wire logic              sleepMode,
    input wire acsq_core_req_type coreReq,
    input wire acsq_core_rsp_type coreRsp,
    input wire logic              irq
);
    logic       wrAny;
    logic       wrCtrl;
    logic       wrClk;
    logic       wrMask;
    logic       auto_sample_start_q;
    logic [3:0] trig_q;
    logic [7:0] div_q;
    logic       mask_q;
    logic       inConv_q;
    logic       seen_q;
    logic [9:0] gap_q;

    // A register write lands at the edge that closes the acknowledge cycle.
    assign wrAny  = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign wrCtrl = wrAny & (wb_adr_i == 8'h00);
    assign wrClk  = wrAny & (wb_adr_i == 8'h04);
    assign wrMask = wrAny & (wb_adr_i == 8'h10);

    // Shadow copies of the settings and a gap counter between clock enables.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            auto_sample_start_q   <= 1'b0;
            trig_q   <= 4'h0;
            div_q    <= 8'h00;
            mask_q   <= 1'b0;
            inConv_q <= 1'b0;
            seen_q   <= 1'b0;
            gap_q    <= 10'h000;
        end else begin
            if (wrCtrl) begin
                auto_sample_start_q <= wb_dat_i[2];
                trig_q <= wb_dat_i[7:4];
            end
            if (wrClk) begin
                div_q <= wb_dat_i[7:0];
            end
            if (wrMask) begin
                mask_q <= wb_dat_i[0];
            end
            inConv_q <= coreReq.convStart | (inConv_q & ~coreRsp.convDone);
            seen_q   <= ~coreReq.convStart & (seen_q | coreReq.convClkEn);
            gap_q    <= coreReq.convClkEn ? 10'h001 : gap_q + {9'h000, gap_q != 10'h3FF};
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // Steps that follow the end of sampling and the end of a conversion.
    sequence sConvFollows;
        ##[0:1] coreReq.convStart;
    endsequence
    sequence sNewSample;
        ##[1:3] coreReq.sampleOn;
    endsequence

    AST_ACK_ONE_CYCLE:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Wishbone acknowledge late");
    AST_ACK_PULSE:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Wishbone acknowledge held too long");
    AST_HOLD_STARTS_CONV:
        assert property ($fell(coreReq.sampleOn) |-> sConvFollows)
        else $error("Hold without conversion start");
    AST_START_PULSE:
        assert property (coreReq.convStart |=> !coreReq.convStart)
        else $error("Conversion start longer than one cycle");
    AST_NO_CLOCK_WHILE_SAMPLING:
        assert property (coreReq.sampleOn |-> !coreReq.convClkEn)
        else $error("Conversion clock while acquiring");
    AST_AUTO_RESTART:
        assert property (coreRsp.convDone && inConv_q && auto_sample_start_q |-> sNewSample)
        else $error("No automatic sampling after conversion");
    AST_MANUAL_START:
        assert property ($rose(coreReq.sampleOn) && !auto_sample_start_q |-> $past(wrCtrl))
        else $error("Sampling began without a software write");
    AST_TAD_PERIOD:
        assert property (coreReq.convClkEn && seen_q && inConv_q
                         |-> gap_q == 10'(2 * (div_q + 1)))
        else $error("Conversion clock period wrong");
    AST_TIMER_RUN_ONLY:
        assert property (trig_q == 4'h5 && sleepMode && timerOneEvt && coreReq.sampleOn
                         |=> coreReq.sampleOn)
        else $error("Timer trigger acted in Sleep");
    AST_DONE_IRQ:
        assert property (coreRsp.convDone && inConv_q && mask_q |=> irq)
        else $error("No interrupt after conversion");
endmodule

bind acsq_sequencer acsq_monitor #(
    .DIV_W   (DIV_W),
    .STIME_W (STIME_W)
) acsq_monitor_inst (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .wb_cyc_i    (wb_cyc_i),
    .wb_stb_i    (wb_stb_i),
    .wb_we_i     (wb_we_i),
    .wb_adr_i    (wb_adr_i),
    .wb_sel_i    (wb_sel_i),
    .wb_dat_i    (wb_dat_i),
    .wb_dat_o    (wb_dat_o),
    .wb_ack_o    (wb_ack_o),
    .timerOneEvt (timerOneEvt),
    .sleepMode   (sleepMode),
    .coreReq     (coreReq),
    .coreRsp     (coreRsp),
    .irq         (irq)
);

`default_nettype wire

// file: verification/acsq_core_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Behavioural sample-and-hold and conversion core.
module acsq_core_model
    import acsq_pkg::*;
#(
    parameter int          CONV_TADS = 4,
    parameter logic [11:0] RES_VAL   = 12'h5A3
) (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // Pace and link.
    input  wire logic              slow,
    input  wire acsq_core_req_type coreReq,
    output acsq_core_rsp_type      coreRsp
);
    logic       busy_q;
    logic [4:0] cnt_q;
    logic [4:0] last;

    // A slow core needs twice the conversion clocks.
    assign last = slow ? 5'(2 * CONV_TADS - 1) : 5'(CONV_TADS - 1);

    // Result lines toggle outside the done pulse, so a stale value never looks valid.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy_q           <= 1'b0;
            cnt_q            <= 5'h00;
            coreRsp.convDone <= 1'b0;
            coreRsp.result   <= ~RES_VAL;
        end else begin
            coreRsp.convDone <= 1'b0;
            coreRsp.result   <= ~coreRsp.result;
            if (coreReq.convStart) begin
                busy_q <= 1'b1;
                cnt_q  <= 5'h00;
            end else if (busy_q && coreReq.convClkEn) begin
                if (cnt_q == last) begin
                    busy_q           <= 1'b0;
                    coreRsp.convDone <= 1'b1;
                    coreRsp.result   <= RES_VAL;
                end else begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Self-checking bench for the sample and conversion sequencer.
module testbench;
    import acsq_pkg::*;
    logic              sys_clk = 1'b0;
    logic              nrst;
    logic              wb_cyc_i;
    logic              wb_stb_i;
    logic              wb_we_i;
    logic [7:0]        wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [31:0]       wb_dat_i;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic              timerOneEvt;
    logic              sleepMode;
    logic              slow;
    logic              irq;
    logic [31:0]       rd;
    acsq_core_req_type coreReq;
    acsq_core_rsp_type coreRsp;
    int                error_cnt = 0;
    int                total_checks = 0;

    always #2 sys_clk = ~sys_clk;

    acsq_sequencer acsq_sequencer_inst (
        .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timerOneEvt(timerOneEvt),
        .sleepMode(sleepMode), .coreReq(coreReq), .coreRsp(coreRsp), .irq(irq)
    );
    acsq_core_model acsq_core_model_inst (
        .sys_clk(sys_clk), .nrst(nrst), .slow(slow), .coreReq(coreReq), .coreRsp(coreRsp)
    );

    // Verdict and end of run.
    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle, held until the acknowledge edge.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(rd & msk, exp);
    endtask

    // Lets n edges pass, then samples at the falling edge.
    task automatic look(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            wb(1'b0, 8'h00, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 40);
        chk({31'h0, rd[0]}, 32'h1);
    endtask

    task automatic t_regs();
        rdchk(8'h00, 32'hFFFFFFFF, 32'h00000000);
        rdchk(8'h04, 32'hFFFFFFFF, 32'h00000100);
        rdchk(8'h10, 32'hFFFFFFFF, 32'h00000000);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        rdchk(8'h20, 32'hFFFFFFFF, 32'h00000000);
    endtask

    task automatic t_manual();
        wb(1'b1, 8'h04, 32'h00000201);
        wb(1'b1, 8'h10, 32'h00000001);
        wb(1'b1, 8'h00, 32'h00008002);
        look(0);
        chk({31'h0, coreReq.sampleOn}, 32'h1);
        rdchk(8'h00, 32'h7, 32'h2);
        look(16);
        wb(1'b1, 8'h00, 32'h00008000);
        rdchk(8'h00, 32'h7, 32'h0);
        wait_done();
        chk(rd & 32'h7, 32'h1);
        look(0);
        chk({31'h0, irq}, 32'h1);
        rdchk(8'h08, 32'hFFF, 32'h5A3);
        rdchk(8'h0C, 32'h1, 32'h1);
        wb(1'b1, 8'h0C, 32'h00000001);
        look(0);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, 8'h00, 32'h00008002);
        rdchk(8'h00, 32'h7, 32'h2);
    endtask

    task automatic t_auto();
        slow <= 1'b1;
        wb(1'b1, 8'h00, 32'h00008076);
        wait_done();
        rdchk(8'h00, 32'h2, 32'h2);
        wb(1'b1, 8'h00, 32'h00008000);
        look(60);
        slow <= 1'b0;
    endtask

    task automatic t_timer(input logic [3:0] code, input logic sleep, input logic conv);
        wb(1'b1, 8'h00, {16'h0, 4'h8, 4'h0, code, 4'h2});
        look(16);
        @(posedge sys_clk);
        sleepMode   <= sleep;
        timerOneEvt <= 1'b1;
        @(posedge sys_clk);
        timerOneEvt <= 1'b0;
        look(2);
        chk({31'h0, coreReq.sampleOn}, {31'h0, !conv});
        look(40);
        @(posedge sys_clk);
        sleepMode <= 1'b0;
    endtask

    task automatic t_mask();
        rdchk(8'h0C, 32'h1, 32'h1);
        wb(1'b1, 8'h10, 32'h00000000);
        look(0);
        chk({31'h0, irq}, 32'h0);
    endtask

    initial begin
        nrst        = 1'b0;
        wb_cyc_i    = 1'b0;
        wb_stb_i    = 1'b0;
        wb_we_i     = 1'b0;
        wb_adr_i    = 8'h00;
        wb_sel_i    = 4'h3;
        wb_dat_i    = 32'h0;
        timerOneEvt = 1'b0;
        sleepMode   = 1'b0;
        slow        = 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_manual();
        t_auto();
        t_timer(4'h5, 1'b1, 1'b0);
        t_timer(4'h5, 1'b0, 1'b1);
        t_timer(4'h6, 1'b1, 1'b1);
        t_timer(4'h3, 1'b0, 1'b0);
        t_mask();
        conclude();
    end

    // Cuts a hang short.
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule

`default_nettype wire
